// *** src/tfc_card.sv ***
// card end: task-file registers, device control, drive address, command acceptance
// Operation
// - write-only control drives interrupt and soft reset
// - host writes bit3 one, bit0 zero
// - control bit 2 resets task-file registers
// - soft reset keeps card configuration register
// - control bit 1 high masks interrupt
// - drive address bits 5:2 invert head
// - drive address bits 7,6,1,0 undefined
// - host should not read drive address
// - decode thirty-nine listed command codes plus the 1X and 7X groups
// - sector codes, 1X recalibrate, 7X seek
// - CD and 38 write without erase
// - sector count spans 00 to FF
// - sector number between 01 and 20
// - head number between 0 and 3
// - act only on own drive number
// - only set features uses feature register
// - command accepted only when ready
// - status read clears level interrupt
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "tfc_cfg.svh"
module tfc_card
   import tfc_pkg::*;
#(
   parameter logic OWN_DRIVE = 1'b0
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // link to host
   tfc_link_if.card lk,
   // operation request to the drive logic
   output logic op_start,
   output logic [7:0] op_code,
   output logic [7:0] op_feature,
   output logic [7:0] op_scount,
   output logic [7:0] op_snum,
   output logic [15:0] op_cyl,
   output logic [3:0] op_head,
   output logic op_abort,
   // operation result from the drive logic
   input wire logic op_done,
   input wire logic op_fail
);
   tfc_dev_s_t s;
   tfc_dev_s_t next_s;
   tfc_use_t uses;
   logic supported;
   logic level_mode;
   logic params_ok;
   logic [7:0] status;

   ////////////////////////////////////////////////////////////////////////////
   tfc_cmd_decode u_dec
   (
      .code(lk.wdata),
      .uses(uses),
      .supported(supported)
   );

   assign level_mode = s.card_cfg[`TFC_CFG_LEVEL];

   // sector count is not checked: every byte value is a legal count
   assign params_ok = !(uses.sn && (s.snum < `TFC_SN_MIN || s.snum > `TFC_SN_MAX))
      && !(uses.hd && s.head > `TFC_HD_MAX);

   always_comb
   begin
      status = 8'h00;
      status[`TFC_ST_BSY] = (s.st != TFC_READY);
      status[`TFC_ST_DRDY] = (s.st == TFC_READY);
      status[`TFC_ST_DSC] = (s.st == TFC_READY);
      status[`TFC_ST_ERR] = s.err && (s.st == TFC_READY);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_s = s;
      next_s.rvalid = 1'b0;
      next_s.op_start = 1'b0;
      // pulse mode: pending lives for one cycle only
      if (!level_mode)
      begin
         next_s.pend = 1'b0;
      end
      if (lk.rd)
      begin
         next_s.rvalid = 1'b1;
         unique case (lk.addr)
            `TFC_A_FEATURE: next_s.rdata = {7'h00, s.err};
            `TFC_A_SCOUNT: next_s.rdata = s.scount;
            `TFC_A_SNUM: next_s.rdata = s.snum;
            `TFC_A_CYL_LO: next_s.rdata = s.cyl[7:0];
            `TFC_A_CYL_HI: next_s.rdata = s.cyl[15:8];
            `TFC_A_DRVHEAD: next_s.rdata = {3'b101, s.drv, s.head};
            `TFC_A_CMD_STAT:
            begin
               next_s.rdata = status;
               // cleared here, before any set below, so a same-cycle event survives
               if (level_mode)
               begin
                  next_s.pend = 1'b0;
               end
            end
            `TFC_A_CARD_CFG: next_s.rdata = s.card_cfg;
            // alternate status leaves the pending interrupt alone
            `TFC_A_CTRL_ALT: next_s.rdata = status;
            // bit7 and write gate fixed, select flags from drive bit: no meaning promised
            `TFC_A_DRV_ADDR: next_s.rdata = {2'b01, ~s.head, ~s.drv, s.drv};
            default: next_s.rdata = 8'h00;
         endcase
      end
      if (lk.wr)
      begin
         unique case (lk.addr)
            `TFC_A_CTRL_ALT:
            begin
               // upper nibble and the fixed bits 3 and 0 are not looked at
               next_s.soft_reset_bit = lk.wdata[`TFC_CTL_SOFT_RESET_BIT];
               next_s.irq_dis = lk.wdata[`TFC_CTL_IRQ_DIS];
            end
            `TFC_A_CARD_CFG: next_s.card_cfg = lk.wdata;
            default:
            begin
               // task file is frozen while busy or in reset
               if (s.st == TFC_READY && !s.soft_reset_bit)
               begin
                  unique case (lk.addr)
                     `TFC_A_FEATURE: next_s.feature = lk.wdata;
                     `TFC_A_SCOUNT: next_s.scount = lk.wdata;
                     `TFC_A_SNUM: next_s.snum = lk.wdata;
                     `TFC_A_CYL_LO: next_s.cyl[7:0] = lk.wdata;
                     `TFC_A_CYL_HI: next_s.cyl[15:8] = lk.wdata;
                     `TFC_A_DRVHEAD:
                     begin
                        next_s.drv = lk.wdata[`TFC_DH_DRV];
                        next_s.head = lk.wdata[3:0];
                     end
                     `TFC_A_CMD_STAT:
                     begin
                        // another drive's command is left to that drive
                        if (s.drv == OWN_DRIVE)
                        begin
                           next_s.err = 1'b0;
                           if (!supported || !params_ok)
                           begin
                              next_s.err = 1'b1;
                              next_s.pend = 1'b1;
                           end
                           else
                           begin
                              next_s.op_start = 1'b1;
                              next_s.op_code = lk.wdata;
                              next_s.st = TFC_BUSY;
                           end
                        end
                     end
                     default:
                     begin
                     end
                  endcase
               end
            end
         endcase
      end
      if (s.st == TFC_BUSY && op_done)
      begin
         next_s.st = TFC_READY;
         next_s.err = op_fail;
         next_s.pend = 1'b1;
      end
      if (s.soft_reset_bit)
      begin
         // card configuration is deliberately not touched
         next_s.st = TFC_RESET;
         next_s.feature = 8'h00;
         next_s.scount = 8'h01;
         next_s.snum = 8'h01;
         next_s.cyl = 16'h0000;
         next_s.drv = 1'b0;
         next_s.head = 4'h0;
         next_s.err = 1'b0;
         next_s.pend = 1'b0;
         next_s.op_start = 1'b0;
      end
      else if (s.st == TFC_RESET)
      begin
         next_s.st = TFC_READY;
      end
      next_s.irq = next_s.pend && !next_s.irq_dis;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
         s.st <= TFC_READY;
         s.card_cfg <= `TFC_CARD_CFG_RST;
         s.scount <= 8'h01;
         s.snum <= 8'h01;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign lk.rdata = s.rdata;
   assign lk.rvalid = s.rvalid;
   assign lk.irq = s.irq;
   assign op_start = s.op_start;
   assign op_code = s.op_code;
   assign op_feature = s.feature;
   assign op_scount = s.scount;
   assign op_snum = s.snum;
   assign op_cyl = s.cyl;
   assign op_head = s.head;
   assign op_abort = s.soft_reset_bit;
endmodule // tfc_card

// *** src/tfc_cfg.svh ***
// task-file control constants: link offsets, bit positions, ranges, host register map
`ifndef TFC_CFG_SVH
`define TFC_CFG_SVH
`define TFC_A_DATA 4'h0
`define TFC_A_FEATURE 4'h1
`define TFC_A_SCOUNT 4'h2
`define TFC_A_SNUM 4'h3
`define TFC_A_CYL_LO 4'h4
`define TFC_A_CYL_HI 4'h5
`define TFC_A_DRVHEAD 4'h6
`define TFC_A_CMD_STAT 4'h7
`define TFC_A_CARD_CFG 4'h8
`define TFC_A_CTRL_ALT 4'hE
`define TFC_A_DRV_ADDR 4'hF
`define TFC_CTL_ONE 3
`define TFC_CTL_SOFT_RESET_BIT 2
`define TFC_CTL_IRQ_DIS 1
`define TFC_CTL_ZERO 0
`define TFC_DH_DRV 4
`define TFC_CFG_LEVEL 6
`define TFC_CARD_CFG_RST 8'h40
`define TFC_ST_BSY 7
`define TFC_ST_DRDY 6
`define TFC_ST_DSC 4
`define TFC_ST_ERR 0
`define TFC_SN_MIN 8'h01
`define TFC_SN_MAX 8'h20
`define TFC_HD_MAX 4'h3
`define TFC_R_ACCESS 8'h00
`define TFC_R_RESULT 8'h04
`define TFC_ACC_READ 12
`define TFC_RES_BUSY 8
`define TFC_RES_IRQ 9
`define TFC_RESP_OK 2'b00
`define TFC_RESP_SLVERR 2'b10
`endif

// *** src/tfc_pkg.sv ***
// task-file control types: states, parameter-use mask and module state records
package tfc_pkg;
   typedef enum logic [2:0] {
      TFC_READY = 3'b001,
      TFC_BUSY = 3'b010,
      TFC_RESET = 3'b100
   } tfc_dev_state_t;

   typedef struct packed {
      logic fr;
      logic sc;
      logic sn;
      logic cy;
      logic hd;
   } tfc_use_t;

   typedef struct packed {
      tfc_dev_state_t st;
      logic soft_reset_bit;
      logic irq_dis;
      logic [7:0] card_cfg;
      logic [7:0] feature;
      logic [7:0] scount;
      logic [7:0] snum;
      logic [15:0] cyl;
      logic drv;
      logic [3:0] head;
      logic err;
      logic pend;
      logic irq;
      logic [7:0] rdata;
      logic rvalid;
      logic op_start;
      logic [7:0] op_code;
   } tfc_dev_s_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic awgot;
      logic wgot;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic lwr;
      logic lrd;
      logic [3:0] laddr;
      logic [7:0] lwdata;
      logic busy;
      logic [7:0] last;
   } tfc_host_s_t;
endpackage

// *** src/tfc_link_if.sv ***
// task-file link between the host controller and the card
`timescale 1ns/10ps
interface tfc_link_if;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic rvalid;
   logic irq;
   modport card (input addr, wdata, wr, rd, output rdata, rvalid, irq);
   modport host (output addr, wdata, wr, rd, input rdata, rvalid, irq);
endinterface // tfc_link_if

// *** src/tfc_cmd_decode.sv ***
// command code decoder: supported set and task-file parameters each code uses
`timescale 1ns/10ps
module tfc_cmd_decode
   import tfc_pkg::*;
(
   // command
   input wire logic [7:0] code,
   // decode
   output tfc_use_t uses,
   output logic supported
);
   always_comb
   begin
      supported = 1'b1;
      uses = '0;
      if (code[7:4] == 4'h1)
      begin
         uses = '0;
      end
      else if (code[7:4] == 4'h7)
      begin
         uses = '{fr: 1'b0, sc: 1'b0, sn: 1'b1, cy: 1'b1, hd: 1'b1};
      end
      else
      begin
         case (code)
            8'hE5, 8'h98, 8'hE1, 8'h95, 8'hE2, 8'h96, 8'hE0, 8'h94, 8'hE6, 8'h99,
            8'h90, 8'hEC, 8'hE4, 8'hE8, 8'h03:
               uses = '0;
            8'hE3, 8'h97, 8'hC6:
               uses.sc = 1'b1;
            8'h91:
               uses = '{fr: 1'b0, sc: 1'b1, sn: 1'b0, cy: 1'b0, hd: 1'b1};
            8'hF5:
               uses.hd = 1'b1;
            8'hEF:
               uses = '{fr: 1'b1, sc: 1'b0, sn: 1'b0, cy: 1'b1, hd: 1'b0};
            8'h50:
               uses = '{fr: 1'b0, sc: 1'b1, sn: 1'b0, cy: 1'b1, hd: 1'b1};
            8'h22, 8'h23, 8'h32, 8'h33:
               uses = '{fr: 1'b0, sc: 1'b0, sn: 1'b1, cy: 1'b1, hd: 1'b1};
            8'h20, 8'h21, 8'h30, 8'h31, 8'h40, 8'h41, 8'hC4, 8'hC5, 8'hC0, 8'h3C, 8'h87:
               uses = '{fr: 1'b0, sc: 1'b1, sn: 1'b1, cy: 1'b1, hd: 1'b1};
            8'hCD, 8'h38:
               uses = '{fr: 1'b0, sc: 1'b1, sn: 1'b1, cy: 1'b1, hd: 1'b1};
            default:
               supported = 1'b0;
         endcase
      end
   end
endmodule // tfc_cmd_decode

// *** src/tfc_host.sv ***
// host end: AXI4-Lite slave that turns register writes into task-file link accesses
`timescale 1ns/10ps
`include "tfc_cfg.svh"
module tfc_host
   import tfc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // link to card
   tfc_link_if.host lk
);
   tfc_host_s_t s;
   tfc_host_s_t next_s;
   logic [3:0] acc_addr;
   logic [7:0] acc_data;
   logic acc_read;
   logic refuse;
   logic [7:0] eff_awaddr;
   logic [31:0] eff_wdata;

   ////////////////////////////////////////////////////////////////////////////
   // address and word as they stand after this edge, built apart from next_s so that
   // the refusal logic does not loop back through the state record
   assign eff_awaddr = (awvalid && s.awready) ? awaddr : s.awaddr;
   assign eff_wdata = !(wvalid && s.wready) ? s.wdata
      : (wstrb[1:0] == 2'b11) ? wdata : 32'h0000_0000;
   assign acc_addr = eff_wdata[11:8];
   assign acc_data = eff_wdata[7:0];
   assign acc_read = eff_wdata[`TFC_ACC_READ];

   always_comb
   begin
      refuse = s.busy || eff_awaddr != `TFC_R_ACCESS;
      if (acc_read && acc_addr == `TFC_A_DRV_ADDR)
      begin
         refuse = 1'b1;
      end
      if (!acc_read && acc_addr == `TFC_A_SNUM
         && (acc_data < `TFC_SN_MIN || acc_data > `TFC_SN_MAX))
      begin
         refuse = 1'b1;
      end
      if (!acc_read && acc_addr == `TFC_A_DRVHEAD && acc_data[3:0] > `TFC_HD_MAX)
      begin
         refuse = 1'b1;
      end
   end

   always_comb
   begin
      next_s = s;
      next_s.lwr = 1'b0;
      next_s.lrd = 1'b0;
      if (s.bvalid && bready)
      begin
         next_s.bvalid = 1'b0;
      end
      if (s.rvalid && rready)
      begin
         next_s.rvalid = 1'b0;
      end
      if (awvalid && s.awready)
      begin
         next_s.awgot = 1'b1;
         next_s.awaddr = awaddr;
      end
      if (wvalid && s.wready)
      begin
         next_s.wgot = 1'b1;
         next_s.wdata = wstrb[1:0] == 2'b11 ? wdata : 32'h0000_0000;
      end
      if (lk.rvalid && s.busy)
      begin
         next_s.busy = 1'b0;
         next_s.last = lk.rdata;
      end
      if (next_s.awgot && next_s.wgot && !next_s.bvalid)
      begin
         next_s.awgot = 1'b0;
         next_s.wgot = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = refuse ? `TFC_RESP_SLVERR : `TFC_RESP_OK;
         if (!refuse)
         begin
            next_s.laddr = acc_addr;
            next_s.lwdata = acc_data;
            next_s.lrd = acc_read;
            next_s.lwr = !acc_read;
            next_s.busy = acc_read;
            // the fixed control bits are forced, whatever software wrote
            if (acc_addr == `TFC_A_CTRL_ALT)
            begin
               next_s.lwdata = {4'h0, 1'b1, acc_data[`TFC_CTL_SOFT_RESET_BIT:`TFC_CTL_IRQ_DIS], 1'b0};
            end
         end
      end
      if (arvalid && s.arready)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp = `TFC_RESP_OK;
         next_s.rdata = 32'h0000_0000;
         if (araddr == `TFC_R_RESULT)
         begin
            // busy here shows only a link read awaiting its answer; a set soft reset does not show
            next_s.rdata = {22'h00_0000, lk.irq, s.busy, s.last};
         end
         else if (araddr != `TFC_R_ACCESS)
         begin
            next_s.rresp = `TFC_RESP_SLVERR;
         end
      end
      next_s.awready = !next_s.awgot && !next_s.bvalid;
      next_s.wready = !next_s.wgot && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign awready = s.awready;
   assign wready = s.wready;
   assign bresp = s.bresp;
   assign bvalid = s.bvalid;
   assign arready = s.arready;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign rvalid = s.rvalid;
   assign lk.addr = s.laddr;
   assign lk.wdata = s.lwdata;
   assign lk.wr = s.lwr;
   assign lk.rd = s.lrd;
endmodule // tfc_host

// *** bench/tfc_link_props.sv ***
// link-side checker for the task-file card end
`timescale 1ns/10ps
`include "tfc_cfg.svh"
module tfc_link_props
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // link
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic irq,
   // drive side
   input wire logic op_start,
   input wire logic op_abort,
   input wire logic op_done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic dis;
   logic lvl;
   logic ctl_wr;
   assign ctl_wr = wr && addr == `TFC_A_CTRL_ALT;
   ////////////////////////////////////////////////////////////////////////////////
   // shadows of the mask and interrupt mode as last written
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dis <= 1'b0;
         lvl <= 1'b1;
      end
      else
      begin
         if (ctl_wr)
            dis <= wdata[`TFC_CTL_IRQ_DIS];
         if (wr && addr == `TFC_A_CARD_CFG)
            lvl <= wdata[`TFC_CFG_LEVEL];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   irq_masked_a: assert property (dis && $past(dis) |-> !irq)
      else $error("interrupt seen while masked");
   abort_set_a: assert property (ctl_wr |=> op_abort == $past(wdata[`TFC_CTL_SOFT_RESET_BIT]))
      else $error("abort does not follow control bit 2");
   abort_hold_a: assert property (op_abort && !ctl_wr |=> op_abort)
      else $error("soft reset left without control write");
   start_cause_a: assert property (op_start |-> $past(wr) && $past(addr) == 4'h7)
      else $error("operation started without command write");
   start_reset_a: assert property (op_start |-> !$past(op_abort))
      else $error("operation started during soft reset");
   start_once_a: assert property (op_start |=> !op_start)
      else $error("operation start longer than one cycle");
   level_clear_a: assert property (rd && addr == 4'h7 && lvl && !op_done |=> !irq)
      else $error("status read did not clear interrupt");
   alt_keep_a: assert property (rd && addr == 4'hE && irq && lvl |=> irq)
      else $error("alternate status read cleared interrupt");
   drv_addr_a: assert property (!(rd && addr == `TFC_A_DRV_ADDR))
      else $error("drive address read on link");
   rd_answer_a: assert property (rd |=> rvalid ##1 !rvalid)
      else $error("read answer missing or long");
endmodule // tfc_link_props

// *** bench/tb.sv ***
// testbench: host over AXI4-Lite, card behind the link, drive logic modelled here
`timescale 1ns/10ps
module tb;
   logic clk, rst;
   logic [7:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready, op_done, op_fail;
   logic [31:0] wdata;
   logic awready, wready, bvalid, arready, rvalid, op_start, op_abort;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, starts, num_errors, checks_done, cyc, n, d;
   logic [7:0] op_code, lastc, b, c, op_feature, op_scount, op_snum;
   logic [15:0] op_cyl;
   logic [3:0] op_head;
   logic [1:0] r;
   tfc_link_if lk_if();
   tfc_host tfc_host_inst (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .lk(lk_if));
   tfc_card #(.OWN_DRIVE(1'b0)) tfc_card_inst (.clk(clk), .rst(rst), .lk(lk_if),
      .op_start(op_start), .op_code(op_code), .op_feature(op_feature), .op_scount(op_scount),
      .op_snum(op_snum), .op_cyl(op_cyl), .op_head(op_head), .op_abort(op_abort),
      .op_done(op_done), .op_fail(op_fail));
   tfc_link_props tfc_link_props_inst (.clk(clk), .rst(rst), .addr(lk_if.addr),
      .wdata(lk_if.wdata), .wr(lk_if.wr), .rd(lk_if.rd), .rdata(lk_if.rdata),
      .rvalid(lk_if.rvalid), .irq(lk_if.irq), .op_start(op_start), .op_abort(op_abort),
      .op_done(op_done));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // each valid drops at the edge that shows its own ready
   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      bready <= 1'b0;
      rs = bresp;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rready <= 1'b0;
      v = rdata;
      rs = rresp;
   endtask
   task automatic lwr(input logic [3:0] a, input logic [7:0] v);
      logic [1:0] rs;
      axw(8'h00, {20'h0, a, v}, rs);
   endtask
   // polls the host busy flag; the global cycle limit bounds the wait
   task automatic lrd(input logic [3:0] a, output logic [7:0] v);
      logic [31:0] x;
      logic [1:0] rs;
      axw(8'h00, {19'h0, 1'b1, a, 8'h00}, rs);
      repeat (3) @(posedge clk);
      x = 32'h100;
      while (x[8] !== 1'b0)
         axr(8'h04, x, rs);
      v = x[7:0];
   endtask
   task automatic done1(input logic f);
      @(posedge clk);
      op_fail <= f;
      op_done <= 1'b1;
      @(posedge clk);
      op_done <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   function automatic logic sup(input logic [7:0] k);
      case (k)
         8'hE5, 8'h98, 8'hE3, 8'h97, 8'hE1, 8'h95, 8'hE2, 8'h96, 8'hE0, 8'h94, 8'hE6, 8'h99,
         8'h90, 8'hEC, 8'hEF, 8'hC6, 8'h87, 8'hF5, 8'hE4, 8'hE8, 8'h91, 8'h50, 8'h03,
         8'h20, 8'h21, 8'h22, 8'h23, 8'h30, 8'h31, 8'h32, 8'h33, 8'h40, 8'h41,
         8'hC4, 8'hC5, 8'hC0, 8'h3C, 8'hCD, 8'h38: return 1'b1;
         default: return k[7:4] == 4'h1 || k[7:4] == 4'h7;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (op_start === 1'b1)
      begin
         starts <= starts + 1;
         lastc <= op_code;
      end
      if (cyc == 32'd60000)
      begin
         num_errors = num_errors + 1;
         finish_test;
      end
   end
   initial
   begin
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      {op_done, op_fail, starts, lastc, num_errors, checks_done, cyc} = '0;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      axr(8'h04, d, r); chk(d, 32'h0);
      lrd(4'h7, b); chk(b, 8'h50);
      lrd(4'h8, b); chk(b, 8'h40);
      axw(8'h08, 32'h0, r); chk(r, 2'b10);
      axr(8'h10, d, r); chk(r, 2'b10);
      axw(8'h00, {19'h0, 1'b1, 4'hF, 8'h00}, r); chk(r, 2'b10);
      // soft reset: task file cleared, commands ignored, configuration kept
      lwr(4'h2, 8'h55);
      lwr(4'hE, 8'h0C);
      repeat (3) @(posedge clk);
      chk(op_abort, 1'b1);
      lrd(4'h7, b); chk(b, 8'h80);
      n = starts;
      lwr(4'h7, 8'h90);
      repeat (3) @(posedge clk);
      chk(starts, n);
      lrd(4'h2, b); chk(b, 8'h01);
      lrd(4'h8, b); chk(b, 8'h40);
      chk(op_abort, 1'b1);
      lwr(4'hE, 8'hF9);
      repeat (3) @(posedge clk);
      chk(op_abort, 1'b0);
      lrd(4'h7, b); chk(b, 8'h50);
      // masked completion, then unmask and alternate read
      lwr(4'hE, 8'h0A);
      lwr(4'h7, 8'h90);
      repeat (3) @(posedge clk);
      done1(1'b0);
      axr(8'h04, d, r); chk(d[9], 1'b0);
      lwr(4'hE, 8'h08);
      repeat (3) @(posedge clk);
      axr(8'h04, d, r); chk(d[9], 1'b1);
      lrd(4'hE, b); chk(b, 8'h50);
      axr(8'h04, d, r); chk(d[9], 1'b1);
      lrd(4'h7, b);
      // parameter ranges
      axw(8'h00, {20'h0, 4'h3, 8'h00}, r); chk(r, 2'b10);
      axw(8'h00, {20'h0, 4'h3, 8'h21}, r); chk(r, 2'b10);
      lwr(4'h3, 8'h20);
      lrd(4'h3, b); chk(b, 8'h20);
      axw(8'h00, {20'h0, 4'h6, 8'hA4}, r); chk(r, 2'b10);
      lwr(4'h6, 8'hA3);
      lrd(4'h6, b); chk(b, 8'hA3);
      for (int i = 0; i < 2; i++)
      begin
         c = (i == 0) ? 8'hFF : 8'h00;
         lwr(4'h2, c);
         lrd(4'h2, b); chk(b, c);
      end
      chk(op_scount, 8'h00);
      chk(op_snum, 8'h20);
      chk(op_head, 4'h3);
      // set features takes the feature byte and the cylinder
      lwr(4'h1, 8'h5A);
      lwr(4'h4, 8'h34);
      lwr(4'h5, 8'h12);
      repeat (2) @(posedge clk);
      chk(op_feature, 8'h5A);
      chk(op_cyl, 16'h1234);
      // every command code; one drive failure on 20h
      for (int i = 0; i < 256; i++)
      begin
         c = i[7:0];
         n = starts;
         lwr(4'h7, c);
         repeat (3) @(posedge clk);
         if (sup(c))
         begin
            chk(starts, n + 1); chk(lastc, c);
            if (c == 8'hEC)
            begin
               lrd(4'h7, b); chk(b, 8'h80);
            end
            done1(c == 8'h20);
         end
         else
            chk(starts, n);
         axr(8'h04, d, r); chk(d[9], 1'b1);
         lrd(4'h7, b); chk(b, (sup(c) && c != 8'h20) ? 8'h50 : 8'h51);
         axr(8'h04, d, r); chk(d[9], 1'b0);
      end
      // command for the other drive number
      lwr(4'h6, 8'hB3);
      n = starts;
      lwr(4'h7, 8'h90);
      repeat (3) @(posedge clk);
      chk(starts, n);
      // error left by the refused FFh stays: a command for the other drive does not clear it
      lrd(4'h7, b); chk(b, 8'h51);
      finish_test;
   end
endmodule // tb
